//--- hw/dxil_pkg.sv
/*
 * Constants for the extract / bit-field merge / indexed load datapath.
 * Assumes a 32-bit core whose decode hands over whole instruction words.
 */
`default_nettype none
package dxil_pkg;
    localparam logic [5:0]  MAJOR_EXT    = 6'h1F;
    localparam logic [5:0]  FN_EXTRACT   = 6'h38;
    localparam logic [5:0]  FN_MERGE     = 6'h0C;
    localparam logic [5:0]  FN_LOAD_IDX  = 6'h0A;
    localparam logic [4:0]  SUB_EXTR     = 5'h01;
    localparam logic [4:0]  SUB_EXTR_R   = 5'h05;
    localparam logic [4:0]  SUB_EXTR_RS  = 5'h07;
    localparam logic [4:0]  SUB_LBU      = 5'h06;
    localparam logic [4:0]  SUB_LH       = 5'h04;
    localparam logic [4:0]  SUB_LW       = 5'h00;
    localparam int          OVF_BIT      = 23;
    localparam logic [31:0] SAT_POS      = 32'h7FFFFFFF;
    localparam logic [31:0] SAT_NEG      = 32'h80000000;
    localparam logic [32:0] TOP_ONES     = 33'h1FFFFFFFF;
    localparam int          NUM_PAIRS    = 4;

    typedef enum logic [1:0] {
        DXIL_IDLE = 2'b00,
        DXIL_WAIT = 2'b01,
        DXIL_DONE = 2'b11
    } dxil_state_t;

    typedef enum logic [2:0] {
        DXIL_EXC_NONE  = 3'h0,
        DXIL_EXC_RSVD  = 3'h1,
        DXIL_EXC_DSPOFF= 3'h2,
        DXIL_EXC_TREF  = 3'h3,
        DXIL_EXC_TINV  = 3'h4,
        DXIL_EXC_BUS   = 3'h5,
        DXIL_EXC_ADDR  = 3'h6,
        DXIL_EXC_WATCH = 3'h7
    } dxil_exc_t;
endpackage : dxil_pkg
`default_nettype wire

//--- hw/dxil_core.sv
/*
 * Datapath for variable word extract, bit-field merge and indexed loads.
 * Assumes the pipeline holds operands stable while busy is high and that the
 * memory path answers each request once with mem_valid, possibly with a fault.
 */
`timescale 1ns/1ps
`default_nettype none

module dxil_core
    import dxil_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic                 issue,
    input  wire logic [31:0]          instr,
    input  wire logic                 dsp_enabled,
    input  wire logic [31:0]          source_operand,
    input  wire logic [31:0]          target_operand,
    input  wire logic [63:0]          pair_value [dxil_pkg::NUM_PAIRS],
    input  wire logic [5:0]           merge_pos,
    input  wire logic [6:0]           merge_size,
    output logic [1:0]                product_sum_pair_select,
    output logic                      mem_req,
    output logic [31:0]               mem_addr,
    output logic [1:0]                mem_size,
    input  wire logic                 mem_valid,
    input  wire logic [31:0]          mem_rdata,
    input  wire logic [2:0]           mem_fault,
    output logic                      busy,
    output logic                      wb_valid,
    output logic [4:0]                wb_dest,
    output logic [31:0]               wb_data,
    output logic                      ovf_set,
    output logic                      exc_valid,
    output dxil_pkg::dxil_exc_t       exc_code
);
    import dxil_pkg::*;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic [5:0] f_major = instr[31:26];
    wire logic [5:0] f_func  = instr[5:0];
    wire logic [4:0] f_sub   = instr[10:6];
    wire logic is_ext    = (f_major == MAJOR_EXT);
    wire logic is_extr   = is_ext && f_func == FN_EXTRACT && instr[15:13] == 3'h0 &&
                           (f_sub == SUB_EXTR || f_sub == SUB_EXTR_R || f_sub == SUB_EXTR_RS);
    wire logic is_merge  = is_ext && f_func == FN_MERGE && instr[15:6] == 10'h000;
    wire logic is_load   = is_ext && f_func == FN_LOAD_IDX &&
                           (f_sub == SUB_LBU || f_sub == SUB_LH || f_sub == SUB_LW);
    wire logic is_known  = is_extr || is_merge || is_load;

    // ------------------------------------------------------------
    // Extract arithmetic
    // ------------------------------------------------------------
    wire logic [4:0]  shamt = source_operand[4:0];
    wire logic [1:0]  pair  = instr[12:11];
    assign product_sum_pair_select = pair;
    // Pairs are read only; nothing here writes an accumulator
    wire logic [63:0] acc   = pair_value[pair];

    // Arithmetic shift of {acc,0} by shamt equals the helper's form for all shifts
    wire logic signed [64:0] acc_ext = {acc, 1'b0};
    wire logic [64:0] shv   = 65'(acc_ext >>> shamt);
    wire logic [64:0] rnd   = shv + 65'h1;

    function automatic logic mixed_top(input logic [64:0] v);
        mixed_top = (v[64:32] != 33'h0) && (v[64:32] != TOP_ONES);
    endfunction : mixed_top

    wire logic ovf_pre  = mixed_top(shv);
    wire logic ovf_rnd  = mixed_top(rnd);
    wire logic [31:0] sat_val = rnd[64] ? SAT_NEG : SAT_POS;
    wire logic [31:0] extr_res =
        (f_sub == SUB_EXTR)   ? shv[32:1] :
        (f_sub == SUB_EXTR_R) ? rnd[32:1] :
        (ovf_rnd ? sat_val : rnd[32:1]);

    // ------------------------------------------------------------
    // Bit-field merge
    // ------------------------------------------------------------
    // Out-of-range pos/size yield whatever the mask gives, never a hang
    wire logic [6:0]  top_excl = 7'(merge_pos + 7'(merge_size));
    wire logic [63:0] upper_m  = (64'h1 << top_excl) - 64'h1;
    wire logic [63:0] lower_m  = (64'h1 << merge_pos) - 64'h1;
    wire logic [31:0] field_m  = upper_m[31:0] & ~lower_m[31:0];
    wire logic [31:0] src_sh   = 32'({32'h0, source_operand} << merge_pos);
    wire logic [31:0] merge_res = (target_operand & ~field_m) | (src_sh & field_m);

    // ------------------------------------------------------------
    // Indexed load address and alignment
    // ------------------------------------------------------------
    wire logic [31:0] eff_addr = source_operand + target_operand;
    wire logic misalign = (f_sub == SUB_LH && eff_addr[0]) ||
                          (f_sub == SUB_LW && eff_addr[1:0] != 2'h0);

    // ------------------------------------------------------------
    // Control
    // ------------------------------------------------------------
    dxil_state_t state_reg;
    dxil_state_t state_next;
    logic [4:0]  ldsub_reg;
    logic [4:0]  lddst_reg;

    wire logic start_ok  = issue && state_reg == DXIL_IDLE;
    wire logic go_load   = start_ok && dsp_enabled && is_load && !misalign;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            DXIL_IDLE: if (go_load) state_next = DXIL_WAIT;
            DXIL_WAIT: if (mem_valid) state_next = DXIL_DONE;
            DXIL_DONE: state_next = DXIL_IDLE;
            default:   state_next = DXIL_IDLE;
        endcase
    end

    assign busy    = state_reg != DXIL_IDLE;
    assign mem_req = state_reg == DXIL_WAIT;

    wire logic [31:0] load_res =
        (ldsub_reg == SUB_LBU) ? {24'h0, mem_rdata[7:0]} :
        (ldsub_reg == SUB_LH)  ? {{16{mem_rdata[15]}}, mem_rdata[15:0]} :
        mem_rdata;

    wire dxil_exc_t start_exc =
        !is_known     ? DXIL_EXC_RSVD :
        !dsp_enabled  ? DXIL_EXC_DSPOFF :
        (is_load && misalign) ? DXIL_EXC_ADDR : DXIL_EXC_NONE;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= DXIL_IDLE;
            ldsub_reg <= 5'h0;
            lddst_reg <= 5'h0;
            mem_addr  <= 32'h0;
            mem_size  <= 2'h0;
            wb_valid  <= 1'b0;
            wb_dest   <= 5'h0;
            wb_data   <= 32'h0;
            ovf_set   <= 1'b0;
            exc_valid <= 1'b0;
            exc_code  <= DXIL_EXC_NONE;
        end else begin
            state_reg <= state_next;
            wb_valid  <= 1'b0;
            ovf_set   <= 1'b0;
            exc_valid <= 1'b0;
            if (start_ok) begin
                if (start_exc != DXIL_EXC_NONE) begin
                    exc_valid <= 1'b1;
                    exc_code  <= start_exc;
                end else if (is_extr) begin
                    wb_valid <= 1'b1;
                    wb_dest  <= instr[20:16];
                    wb_data  <= extr_res;
                    ovf_set  <= ovf_pre || ovf_rnd;
                end else if (is_merge) begin
                    wb_valid <= 1'b1;
                    wb_dest  <= instr[20:16];
                    wb_data  <= merge_res;
                end else begin
                    ldsub_reg <= f_sub;
                    lddst_reg <= instr[15:11];
                    mem_addr  <= eff_addr;
                    mem_size  <= (f_sub == SUB_LBU) ? 2'h0 : (f_sub == SUB_LH) ? 2'h1 : 2'h2;
                end
            end else if (state_reg == DXIL_WAIT && mem_valid) begin
                if (mem_fault != 3'h0) begin
                    exc_valid <= 1'b1;
                    exc_code  <= dxil_exc_t'(mem_fault);
                end else begin
                    wb_valid <= 1'b1;
                    wb_dest  <= lddst_reg;
                    wb_data  <= load_res;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_aligned_word_issue;
        start_ok && dsp_enabled && is_load && f_sub == SUB_LW && eff_addr[1:0] == 2'h0;
    endsequence

    property p_misalign_fault;
        @(posedge clk) disable iff (!rstn)
        (start_ok && is_load && dsp_enabled && misalign) |=> exc_valid && exc_code == DXIL_EXC_ADDR && !mem_req;
    endproperty
    a_misalign_fault: assert property (p_misalign_fault) else $error("misaligned load not faulted");

    property p_word_req;
        @(posedge clk) disable iff (!rstn)
        s_aligned_word_issue |=> mem_req && mem_size == 2'h2 && mem_addr == $past(eff_addr);
    endproperty
    a_word_req: assert property (p_word_req) else $error("word load request wrong");

    property p_extr_ovf;
        @(posedge clk) disable iff (!rstn)
        (start_ok && dsp_enabled && is_extr) |=> ovf_set == $past(ovf_pre || ovf_rnd) && wb_valid;
    endproperty
    a_extr_ovf: assert property (p_extr_ovf) else $error("extract overflow flag wrong");

    property p_sat;
        @(posedge clk) disable iff (!rstn)
        (start_ok && dsp_enabled && is_extr && f_sub == SUB_EXTR_RS && ovf_rnd)
            |=> wb_data == $past(rnd[64] ? SAT_NEG : SAT_POS);
    endproperty
    a_sat: assert property (p_sat) else $error("saturation value wrong");

    property p_plain;
        @(posedge clk) disable iff (!rstn)
        (start_ok && dsp_enabled && is_extr && f_sub == SUB_EXTR) |=> wb_data == $past(shv[32:1]);
    endproperty
    a_plain: assert property (p_plain) else $error("plain extract wrong");

    property p_merge_keep;
        @(posedge clk) disable iff (!rstn)
        (start_ok && dsp_enabled && is_merge) |=> ((wb_data ^ $past(target_operand)) & ~$past(field_m)) == 32'h0;
    endproperty
    a_merge_keep: assert property (p_merge_keep) else $error("merge disturbed outside field");

    property p_rsvd;
        @(posedge clk) disable iff (!rstn)
        (start_ok && !is_known) |=> exc_valid && exc_code == DXIL_EXC_RSVD && !wb_valid;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved instruction not flagged");

    property p_half_sext;
        @(posedge clk) disable iff (!rstn)
        (mem_req && mem_valid && mem_fault == 3'h0 && ldsub_reg == SUB_LH)
            |=> wb_valid && wb_data == {{16{$past(mem_rdata[15])}}, $past(mem_rdata[15:0])};
    endproperty
    a_half_sext: assert property (p_half_sext) else $error("halfword not sign-extended");

    property p_byte_zext;
        @(posedge clk) disable iff (!rstn)
        (mem_req && mem_valid && mem_fault == 3'h0 && ldsub_reg == SUB_LBU) |=> wb_data[31:8] == 24'h0;
    endproperty
    a_byte_zext: assert property (p_byte_zext) else $error("byte not zero-extended");

    sequence s_word_answer;
        mem_req && mem_valid && mem_fault == 3'h0 && ldsub_reg == SUB_LW;
    endsequence

    property p_word_pass;
        @(posedge clk) disable iff (!rstn)
        s_word_answer |=> wb_valid && wb_data == $past(mem_rdata) && wb_dest == $past(lddst_reg);
    endproperty
    a_word_pass: assert property (p_word_pass) else $error("word load not passed unchanged");

    property p_mem_fault;
        @(posedge clk) disable iff (!rstn)
        (mem_req && mem_valid && mem_fault != 3'h0) |=> exc_valid && exc_code == $past(mem_fault) && !wb_valid;
    endproperty
    a_mem_fault: assert property (p_mem_fault) else $error("memory fault not reported");

    property p_dspoff;
        @(posedge clk) disable iff (!rstn)
        (start_ok && is_known && !dsp_enabled) |=> exc_valid && exc_code == DXIL_EXC_DSPOFF && !busy;
    endproperty
    a_dspoff: assert property (p_dspoff) else $error("disabled extension not flagged");

    // Carry out of bit 0 into bit 1 is exactly bit 0, so this avoids the design's adder
    property p_round;
        @(posedge clk) disable iff (!rstn)
        (start_ok && dsp_enabled && is_extr && f_sub == SUB_EXTR_R) |=> wb_data == $past(shv[32:1] + {31'h0, shv[0]});
    endproperty
    a_round: assert property (p_round) else $error("rounding extract wrong");

    property p_merge_field;
        @(posedge clk) disable iff (!rstn)
        (start_ok && dsp_enabled && is_merge) |=> ((wb_data ^ $past(src_sh)) & $past(field_m)) == 32'h0;
    endproperty
    a_merge_field: assert property (p_merge_field) else $error("merge field bits wrong");

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    // The selector field is two bits wide, so exactly four pairs can be served
    if (NUM_PAIRS != 4) begin : g_pairs_check
        $error("pair count must be four");
    end

endmodule : dxil_core

`default_nettype wire

//--- dv/dxil_mem_model.sv
/* Data-memory side model for dxil_core loads.
   Assumes mem_req stays up until mem_valid; answers after a set delay. */
`timescale 1ns/1ps
`default_nettype none
module dxil_mem_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    input  wire logic [1:0]  mem_size,
    input  wire logic [3:0]  delay,
    input  wire logic [2:0]  fault,
    output logic             mem_valid,
    output logic [31:0]      mem_rdata,
    output logic [2:0]       mem_fault
);
    logic [3:0]  cnt_reg;
    logic [31:0] last_reg;
    logic [31:0] w;
    logic [31:0] lanes;
    function automatic logic [31:0] word_at(input logic [31:0] a);
        return (a * 32'h9E3779B1) ^ 32'h5AA5C33C;
    endfunction : word_at
    // Unit repeated on every lane, so any lane pick by the core sees it
    assign w     = word_at(mem_addr);
    assign lanes = (mem_size == 2'h0) ? {4{w[7:0]}} : (mem_size == 2'h1) ? {2{w[15:0]}} : w;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg   <= 4'h0;
            mem_valid <= 1'b0;
            last_reg  <= 32'h0;
        end else begin
            mem_valid <= 1'b0;
            if (mem_req && !mem_valid) begin
                cnt_reg <= (cnt_reg == delay) ? 4'h0 : cnt_reg + 4'h1;
                if (cnt_reg == delay) begin
                    mem_valid <= 1'b1;
                    last_reg  <= lanes;
                end
            end
        end
    end
    // Outside the answer cycle the lines carry garbage, never the last value
    assign mem_rdata = mem_valid ? last_reg : ~last_reg;
    assign mem_fault = mem_valid ? fault : ~fault;
endmodule : dxil_mem_model
`default_nettype wire

//--- dv/tb.sv
/* Self-checking bench for dxil_core: queues expected results as it issues.
   Assumes dxil_mem_model on the memory side. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dxil_pkg::*;
    typedef struct {logic is_exc; dxil_exc_t code; logic [4:0] dest; logic [31:0] data; logic ovf;} dxil_note_t;
    logic        clk, rstn, issue, dsp_enabled, busy, wb_valid, ovf_set, exc_valid, mem_req, mem_valid, no_req;
    logic [31:0] instr, source_operand, target_operand, mem_addr, mem_rdata, wb_data, ea, ins, exp_addr, w;
    logic [63:0] pv [NUM_PAIRS];
    logic [63:0] tmp, mask;
    logic [5:0]  merge_pos;
    logic [6:0]  merge_size;
    logic [4:0]  wb_dest, sub, rt;
    logic [1:0]  product_sum_pair_select, mem_size, ac, exp_size;
    logic [2:0]  mem_fault, fault;
    logic [3:0]  delay;
    dxil_exc_t   exc_code;
    dxil_note_t  notes [$];
    dxil_note_t  got;
    int          num_errors, comparisons, i, j, k, p, s;
    dxil_core u_dxil_core (.clk(clk), .rstn(rstn), .issue(issue), .instr(instr), .dsp_enabled(dsp_enabled),
        .source_operand(source_operand), .target_operand(target_operand), .pair_value(pv), .merge_pos(merge_pos),
        .merge_size(merge_size), .product_sum_pair_select(product_sum_pair_select), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_size(mem_size), .mem_valid(mem_valid), .mem_rdata(mem_rdata),
        .mem_fault(mem_fault), .busy(busy), .wb_valid(wb_valid), .wb_dest(wb_dest), .wb_data(wb_data),
        .ovf_set(ovf_set), .exc_valid(exc_valid), .exc_code(exc_code));
    dxil_mem_model u_dxil_mem_model (.clk(clk), .rstn(rstn), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_size(mem_size), .delay(delay), .fault(fault), .mem_valid(mem_valid), .mem_rdata(mem_rdata),
        .mem_fault(mem_fault));
    always #20 clk = ~clk;
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic report_and_stop();
        if (num_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    function automatic dxil_note_t note(input logic x, input dxil_exc_t c, input logic [4:0] d,
                                        input logic [31:0] v, input logic o);
        dxil_note_t r;
        r = '{x, c, d, v, o};
        return r;
    endfunction : note
    function automatic dxil_note_t exp_extract(input logic [4:0] sb, input logic [63:0] acc, input logic [4:0] sh,
                                               input logic [4:0] dst);
        logic [64:0] t;
        logic [64:0] t2;
        logic        o1;
        logic        o2;
        logic [96:0] x;
        x  = {{33{acc[63]}}, acc};
        t  = (sh == 5'h0) ? {acc, 1'b0} : 65'(x >> (sh - 5'h1));
        t2 = t + 65'h1;
        o1 = t[64:32] != 33'h0 && t[64:32] != TOP_ONES;
        o2 = t2[64:32] != 33'h0 && t2[64:32] != TOP_ONES;
        if (sb == SUB_EXTR_RS && o2) return note(1'b0, DXIL_EXC_NONE, dst, t2[64] ? SAT_NEG : SAT_POS, 1'b1);
        return note(1'b0, DXIL_EXC_NONE, dst, (sb == SUB_EXTR) ? t[32:1] : t2[32:1], o1 | o2);
    endfunction : exp_extract
    // Issue is left high between plain ops so they go back to back
    task automatic op(input logic [31:0] code, input logic [31:0] src, input logic [31:0] tgt);
        issue = 1'b1;
        instr = code;
        source_operand = src;
        target_operand = tgt;
        @(posedge clk);
        #1;
        if (code[5:0] == FN_EXTRACT) check("pair select", product_sum_pair_select, code[12:11]);
        if (code[5:0] == FN_LOAD_IDX) begin
            instr = ~code;
            for (k = 0; busy === 1'b1 && k < 60; k++) begin
                @(posedge clk);
                #1;
            end
            check("load finish", busy, 1'b0);
            issue = 1'b0;
            @(posedge clk);
            #1;
        end
    endtask : op
    always @(negedge clk) begin
        if (wb_valid === 1'b1 || exc_valid === 1'b1) begin
            check("result expected", notes.size() != 0, 1'b1);
            if (notes.size() != 0) begin
                got = notes.pop_front();
                check("exc_valid", exc_valid, got.is_exc);
                if (got.is_exc) check("exc_code", exc_code, got.code);
                else begin
                    check("wb_dest", wb_dest, got.dest);
                    check("wb_data", wb_data, got.data);
                    check("ovf_set", ovf_set, got.ovf);
                end
            end
        end
        if (mem_req === 1'b1) begin
            check("mem_req allowed", no_req, 1'b0);
            check("mem_addr", mem_addr, exp_addr);
            check("mem_size", mem_size, exp_size);
        end
    end
    initial begin
        #2000000;
        num_errors++;
        report_and_stop();
    end
    initial begin
        {clk, rstn, issue, instr, source_operand, target_operand, merge_pos, delay, fault, no_req} = '0;
        {dsp_enabled, merge_size, exp_addr, exp_size} = '0;
        foreach (pv[n]) pv[n] = 64'h0;
        void'($urandom(32'hAC2DD561));
        repeat (12) @(posedge clk);
        check("quiet in reset", {busy, mem_req, wb_valid, exc_valid}, 4'h0);
        #1 rstn = 1'b1;
        dsp_enabled = 1'b1;
        for (i = 0; i < 60; i++) begin
            sub = (i % 3 == 0) ? SUB_EXTR : (i % 3 == 1) ? SUB_EXTR_R : SUB_EXTR_RS;
            ac = 2'($urandom);
            rt = 5'($urandom);
            for (j = 0; j < NUM_PAIRS; j++) begin
                tmp = {$urandom, $urandom};
                if ($urandom % 2) tmp[63:32] = {32{tmp[31]}} ^ ($urandom % 4);
                if (i < 3 && j == ac) tmp = 64'h00000000FFFFFFFF;
                pv[j] = tmp;
            end
            w = (i < 3) ? 32'hFFFFFFE1 : (i < 6) ? 32'hFFFFFFE0 : $urandom;
            notes.push_back(exp_extract(sub, (i < 3) ? 64'h00000000FFFFFFFF : tmp, w[4:0], rt));
            if (i >= 3) notes[$] = exp_extract(sub, pv[ac], w[4:0], rt);
            op({MAJOR_EXT, 5'h3, rt, 3'h0, ac, sub, FN_EXTRACT}, w, $urandom);
        end
        for (i = 0; i < 30; i++) begin
            p = (i == 0) ? 0 : (i == 1) ? 31 : $urandom % 32;
            s = (i == 0) ? 32 : (i == 1) ? 1 : 1 + $urandom % (32 - p);
            mask = ((64'h1 << s) - 64'h1) << p;
            {merge_pos, merge_size} = {p[5:0], s[6:0]};
            w = $urandom;
            ea = $urandom;
            rt = 5'($urandom);
            notes.push_back(note(1'b0, DXIL_EXC_NONE, rt, (ea & ~mask[31:0]) | ((w << p) & mask[31:0]), 1'b0));
            op({MAJOR_EXT, 5'h2, rt, 10'h0, FN_MERGE}, w, ea);
        end
        no_req = 1'b1;
        for (i = 0; i < 6; i++) begin
            ins = (i == 0) ? {MAJOR_EXT, 10'h0, 10'h040, FN_MERGE} : (i == 1) ? {MAJOR_EXT, 15'h0, 5'h1F, FN_LOAD_IDX}
                : (i == 2) ? {MAJOR_EXT, 10'h0, 3'h1, 2'h0, SUB_EXTR, FN_EXTRACT} : (i == 3) ? {MAJOR_EXT, 20'h0, 6'h3F}
                : (i == 4) ? {MAJOR_EXT, 15'h0, SUB_EXTR, FN_EXTRACT} : {MAJOR_EXT, 15'h0, SUB_LW, FN_LOAD_IDX};
            dsp_enabled = (i < 4);
            notes.push_back(note(1'b1, (i < 4) ? DXIL_EXC_RSVD : DXIL_EXC_DSPOFF, 5'h0, 32'h0, 1'b0));
            op(ins, 32'h0, 32'h0);
        end
        dsp_enabled = 1'b1;
        for (i = 0; i < 24; i++) begin
            sub = (i % 3 == 0) ? SUB_LBU : (i % 3 == 1) ? SUB_LH : SUB_LW;
            exp_size = 2'(i % 3);
            w = $urandom;
            ea = $urandom;
            ea = ea - ((w + ea) & ((i % 3 == 0) ? 32'h0 : (i % 3 == 1) ? 32'h1 : 32'h3)) + (i % 4 == 3);
            exp_addr = w + ea;
            no_req = (exp_size != 2'h0) && (exp_addr[0] || (exp_size == 2'h2 && exp_addr[1]));
            fault = (i >= 12 && i < 17) ? 3'(i - 9) : 3'h0;
            delay = 4'($urandom % 8);
            rt = 5'($urandom);
            tmp[31:0] = u_dxil_mem_model.word_at(exp_addr);
            tmp[31:0] = (i % 3 == 0) ? {24'h0, tmp[7:0]} : (i % 3 == 1) ? {{16{tmp[15]}}, tmp[15:0]} : tmp[31:0];
            if (no_req) notes.push_back(note(1'b1, DXIL_EXC_ADDR, 5'h0, 32'h0, 1'b0));
            else if (fault != 3'h0) notes.push_back(note(1'b1, dxil_exc_t'(fault), 5'h0, 32'h0, 1'b0));
            else notes.push_back(note(1'b0, DXIL_EXC_NONE, rt, tmp[31:0], 1'b0));
            op({MAJOR_EXT, 5'h4, 5'h5, rt, sub, FN_LOAD_IDX}, w, ea);
        end
        issue = 1'b0;
        for (k = 0; notes.size() != 0 && k < 20; k++) @(posedge clk);
        check("all results seen", notes.size(), 0);
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
